// >>> core/seqmk_defines.svh
// Purpose: constants for the sequencer marker / reload flag block
// Assumes: included by bare name from core files
// Notes: definitions only
`ifndef SEQMK_DEFINES_SVH
`define SEQMK_DEFINES_SVH

// marker run lengths in clocks
`define SEQMK_LEN_NONE 2'h0
`define SEQMK_LEN_BOUNDARY 2'h1
`define SEQMK_LEN_DEFERRED 2'h2
`define SEQMK_LEN_IMMEDIATE 2'h3

// longest run that is not the halted indication
`define SEQMK_RUN_MAX 3'h3

// reset values
`define SEQMK_MARKER_RST 1'h0
`define SEQMK_RELOAD_RST 1'h0

`endif

// >>> core/seqmk_marker.sv
// Purpose: sequencer state marker and pipeline reload flag for trace capture
// Assumes: event inputs are one-cycle pulses synchronous to core_clk rising edge
// Notes: both outputs are retimed onto the falling edge by seqmk_out_stage
`timescale 1ns/1ps
`include "seqmk_defines.svh"

// Function
// - instruction boundary gives one-clock marker
// - boundary with pending trace/interrupt gives two clocks
// - translation cache miss gives three clocks
// - immediate exceptions also give three clocks
// - double bus fault holds marker asserted
// - external bus hold never stops sequencer
// - outputs follow sequencer, not bus cycles
// - reload flag asserts on every reload request
// - branches, jumps, traps, returns, status writes reload
// - condition-code-only operations cause no reload
// - whole status word load causes reload
// - translation control change causes reload
// - loop instruction: reload before test, again if false
// - marker and reload flag timed independently
// - both outputs launched from falling edge
// - trace/interrupt entry raises reload before handler
// - three-clock markings happen immediately, not at boundaries
// - bus error before handler's first instruction halts
// - halted marking persists until reset
// - error during reset vector fetch halts
module seqmk_marker #(
  parameter int LEN_W = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // instruction boundary events
  input wire logic ev_boundary,
  input wire logic ev_pend_trace,
  input wire logic ev_pend_irq,
  // immediate events: translation miss and exceptions
  input wire logic ev_atc_miss,
  input wire logic ev_exc_reset,
  input wire logic ev_bus_error,
  input wire logic ev_addr_error,
  input wire logic ev_spurious,
  input wire logic ev_autovector,
  input wire logic ev_cp_escape_noresp,
  // exception progress
  input wire logic ev_handler_first_instr,
  input wire logic ev_startup_done,
  // reload causes
  input wire logic rl_branch,
  input wire logic rl_jump,
  input wire logic rl_trap,
  input wire logic rl_return,
  input wire logic rl_cp_flow,
  input wire logic rl_flag_register_load_instr,
  input wire logic rl_translation_control_load_instr,
  input wire logic rl_exc_entry,
  input wire logic rl_cc_only,
  input wire logic rl_loop_start,
  input wire logic rl_loop_cond_false,
  // external bus hold, bus side only
  input wire logic bus_hold_input,
  // trace outputs
  output logic sequencer_marker,
  output logic pipeline_reload_flag
);

  // the run-length codes are fixed at two bits, so any other width is refused
  if (LEN_W != 2)
  begin : g_len_w_check
    $error("seqmk_marker: LEN_W must be 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // event decode

  function automatic seqmk_pkg::seqmk_len_t len_max(input seqmk_pkg::seqmk_len_t a,
                                                    input seqmk_pkg::seqmk_len_t b);
    len_max = (a > b) ? a : b;
  endfunction

  seqmk_pkg::seqmk_state_e state_reg;
  seqmk_pkg::seqmk_state_e state_next;
  seqmk_pkg::seqmk_len_t cnt_reg;
  seqmk_pkg::seqmk_len_t cnt_next;
  seqmk_pkg::seqmk_len_t pend_reg;
  seqmk_pkg::seqmk_len_t pend_next;
  logic berr_win_reg;
  logic berr_win_next;
  logic boot_win_reg;
  logic boot_win_next;
  logic halt_reg;
  logic halt_next;
  logic reload_reg;
  logic reload_next;
  logic reload_pend_reg;
  logic reload_pend_next;

  wire logic deferred = ev_boundary & (ev_pend_trace | ev_pend_irq);
  wire logic imm_exc = ev_exc_reset | ev_bus_error | ev_addr_error | ev_spurious | ev_autovector
                     | ev_cp_escape_noresp;
  wire logic imm_any = ev_atc_miss | imm_exc;
  // a second bus error inside the handler-entry window is fatal
  wire logic dbl_fault = berr_win_reg & ev_bus_error;
  // errors while fetching the reset vectors or first prefetch are fatal too
  wire logic boot_fault = boot_win_reg & (ev_bus_error | ev_addr_error);
  wire logic halt_cause = dbl_fault | boot_fault;
  wire logic halt_any = halt_reg | halt_cause;

  // immediate exceptions are marked at once, without waiting for a boundary
  wire seqmk_pkg::seqmk_len_t req_len =
    imm_any ? `SEQMK_LEN_IMMEDIATE :
    deferred ? `SEQMK_LEN_DEFERRED :
    ev_boundary ? `SEQMK_LEN_BOUNDARY :
    `SEQMK_LEN_NONE;
  wire seqmk_pkg::seqmk_len_t gap_len = len_max(pend_reg, req_len);
  wire logic marker_int = (state_reg == seqmk_pkg::SEQMK_PULSE) || (state_reg == seqmk_pkg::SEQMK_HALT);

  ////////////////////////////////////////////////////////////////////////////
  // fault windows and halt latch

  // set wins over clear when a bus error and the handler start coincide
  assign berr_win_next = ev_bus_error | (berr_win_reg & ~ev_handler_first_instr);
  assign boot_win_next = ev_exc_reset | (boot_win_reg & ~ev_startup_done);
  assign halt_next = halt_any;

  ////////////////////////////////////////////////////////////////////////////
  // marker sequencer

  // bus_hold_input is deliberately absent: it stalls bus cycles, not this sequencer
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pend_next = pend_reg;
    unique case (state_reg)
      seqmk_pkg::SEQMK_IDLE:
      begin
        if (halt_any)
          state_next = seqmk_pkg::SEQMK_HALT;
        else if (req_len != `SEQMK_LEN_NONE)
        begin
          state_next = seqmk_pkg::SEQMK_PULSE;
          cnt_next = req_len - 2'h1;
        end
      end
      seqmk_pkg::SEQMK_PULSE:
      begin
        // an event during a run waits; coinciding events keep only the longest
        pend_next = len_max(pend_reg, req_len);
        if (halt_any)
          state_next = seqmk_pkg::SEQMK_HALT;
        else if (cnt_reg == 2'h0)
          state_next = seqmk_pkg::SEQMK_GAP;
        else
          cnt_next = cnt_reg - 2'h1;
      end
      seqmk_pkg::SEQMK_GAP:
      begin
        pend_next = `SEQMK_LEN_NONE;
        if (halt_any)
          state_next = seqmk_pkg::SEQMK_HALT;
        else if (gap_len != `SEQMK_LEN_NONE)
        begin
          state_next = seqmk_pkg::SEQMK_PULSE;
          cnt_next = gap_len - 2'h1;
        end
        else
          state_next = seqmk_pkg::SEQMK_IDLE;
      end
      seqmk_pkg::SEQMK_HALT:
      begin
        state_next = seqmk_pkg::SEQMK_HALT;
      end
      default:
      begin
        state_next = seqmk_pkg::SEQMK_HALT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // reload requests

  // independent of the marker path: no alignment with marker pulses
  wire logic reload_req = rl_branch | rl_jump | rl_trap | rl_return | rl_cp_flow
                        | rl_flag_register_load_instr
                        | rl_translation_control_load_instr
                        | rl_exc_entry | deferred
                        | rl_loop_start | rl_loop_cond_false;
  // back-to-back requests are split by one low clock; a request arriving while one is pending merges with it
  assign reload_next = (reload_req | reload_pend_reg) & ~reload_reg;
  assign reload_pend_next = (reload_req | reload_pend_reg) & reload_reg;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= seqmk_pkg::SEQMK_IDLE;
      cnt_reg <= `SEQMK_LEN_NONE;
      pend_reg <= `SEQMK_LEN_NONE;
      berr_win_reg <= 1'h0;
      boot_win_reg <= 1'h0;
      halt_reg <= 1'h0;
      reload_reg <= `SEQMK_RELOAD_RST;
      reload_pend_reg <= 1'h0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pend_reg <= pend_next;
      berr_win_reg <= berr_win_next;
      boot_win_reg <= boot_win_next;
      halt_reg <= halt_next;
      reload_reg <= reload_next;
      reload_pend_reg <= reload_pend_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // falling-edge launch

  seqmk_out_stage #(
    .WIDTH(2)
  ) u_out (
    .core_clk(core_clk),
    .resetn(resetn),
    .din({marker_int, reload_reg}),
    .dout({sequencer_marker, pipeline_reload_flag})
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [2:0] run_cnt_reg;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      run_cnt_reg <= 3'h0;
    else if (!marker_int)
      run_cnt_reg <= 3'h0;
    else if (run_cnt_reg != 3'h7)
      run_cnt_reg <= run_cnt_reg + 3'h1;
  end

  wire logic idle_clean = (state_reg == seqmk_pkg::SEQMK_IDLE) && !halt_cause;

  AST_ONE_CLOCK: assert property (@(posedge core_clk) disable iff (!resetn)
    idle_clean && ev_boundary && !ev_pend_trace && !ev_pend_irq && !imm_any |=> marker_int ##1 !marker_int)
    else $error("boundary marker is not one clock");

  AST_TWO_CLOCK: assert property (@(posedge core_clk) disable iff (!resetn)
    idle_clean && deferred && !imm_any |=> marker_int [*2] ##1 !marker_int)
    else $error("deferred boundary marker is not two clocks");

  AST_THREE_MISS: assert property (@(posedge core_clk) disable iff (!resetn)
    idle_clean && ev_atc_miss ##1 !halt_any [*3] |->
    ($past(marker_int, 2) && $past(marker_int, 1) && marker_int) ##1 !marker_int)
    else $error("translation miss marker is not three clocks");

  AST_THREE_EXC: assert property (@(posedge core_clk) disable iff (!resetn)
    idle_clean && imm_exc && !ev_boundary ##1 (!halt_cause && !halt_reg) [*3] |=> !marker_int)
    else $error("immediate exception marker runs past three clocks");

  AST_HALT_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(halt_reg) |-> ##[0:1] (marker_int && state_reg == seqmk_pkg::SEQMK_HALT) ##1 marker_int [*8])
    else $error("halted marker not held");

  AST_DOUBLE_FAULT: assert property (@(posedge core_clk) disable iff (!resetn)
    berr_win_reg && ev_bus_error |=> halt_reg ##1 marker_int)
    else $error("double bus fault did not halt");

  AST_BOOT_FAULT: assert property (@(posedge core_clk) disable iff (!resetn)
    boot_win_reg && ev_addr_error |=> halt_reg)
    else $error("fault during reset vector fetch did not halt");

  AST_HOLD_IGNORED: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_hold_input && state_reg == seqmk_pkg::SEQMK_PULSE && cnt_reg != 2'h0 && !halt_any
    |=> state_reg == seqmk_pkg::SEQMK_PULSE)
    else $error("bus hold disturbed the sequencer marker");

  AST_RUN_BOUND: assert property (@(posedge core_clk) disable iff (!resetn)
    run_cnt_reg > `SEQMK_RUN_MAX |-> state_reg == seqmk_pkg::SEQMK_HALT)
    else $error("marker run longer than three clocks without halt");

  AST_RELOAD: assert property (@(posedge core_clk) disable iff (!resetn)
    reload_req && !reload_reg |=> reload_reg)
    else $error("reload request not flagged");

  AST_LOOP_SPLIT: assert property (@(posedge core_clk) disable iff (!resetn)
    reload_req && reload_reg |=> !reload_reg ##1 reload_reg)
    else $error("back-to-back reload requests merged");

  AST_CC_ONLY: assert property (@(posedge core_clk) disable iff (!resetn)
    rl_cc_only && !reload_req && !reload_pend_reg |=> !reload_reg)
    else $error("condition-code-only operation caused a reload");

  COV_BOUNDARY: cover property (@(posedge core_clk) disable iff (!resetn)
    !marker_int ##1 marker_int ##1 !marker_int);
  COV_DEFERRED: cover property (@(posedge core_clk) disable iff (!resetn)
    deferred ##1 marker_int [*2] ##1 !marker_int);
  COV_HALT: cover property (@(posedge core_clk) disable iff (!resetn)
    dbl_fault ##2 state_reg == seqmk_pkg::SEQMK_HALT);
  COV_LOOP: cover property (@(posedge core_clk) disable iff (!resetn)
    rl_loop_start ##1 rl_loop_cond_false);

endmodule // seqmk_marker

// >>> core/seqmk_out_stage.sv
// Purpose: launch stage that moves posedge-timed levels onto the falling edge
// Assumes: din changes only after rising edges of core_clk
// Notes: half-cycle retime gives observers a full half period of setup
`timescale 1ns/1ps
`include "seqmk_defines.svh"

module seqmk_out_stage #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // refused at elaboration, before any logic is built
  if (WIDTH < 1)
  begin : g_width_check
    $error("seqmk_out_stage: WIDTH must be at least 1");
  end

  always_ff @(negedge core_clk or negedge resetn)
  begin
    if (!resetn)
      dout <= '0;
    else
      dout <= din;
  end

  // at each rising edge the output already carries the level set one edge before
  AST_LAUNCH_NEGEDGE: assert property (@(posedge core_clk) disable iff (!resetn) dout == din)
    else $error("output not launched from the falling edge");

endmodule // seqmk_out_stage

// >>> core/seqmk_pkg.sv
// Purpose: types for the sequencer marker / reload flag block
// Assumes: used as seqmk_pkg::name, never imported
// Notes: constants live in seqmk_defines.svh
package seqmk_pkg;

  typedef logic [1:0] seqmk_len_t;

  typedef enum logic [3:0] {
    SEQMK_IDLE  = 4'h1,
    SEQMK_PULSE = 4'h2,
    SEQMK_GAP   = 4'h4,
    SEQMK_HALT  = 4'h8
  } seqmk_state_e;

endpackage

// >>> tb/seqmk_capture.sv
// Purpose: trace capture model that classifies marker runs and counts reload pulses
// Assumes: outputs are sampled on the rising edge, half a clock after launch
// Notes: bad_edge counts output changes seen while core_clk is high
`timescale 1ns/1ps

module seqmk_capture (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // observed trace outputs
  input wire logic sequencer_marker,
  input wire logic pipeline_reload_flag,
  // classification results
  output logic [7:0] run_cnt,
  output logic [7:0] last_len,
  output logic [7:0] n_runs,
  output logic [7:0] n_reload,
  output logic [7:0] bad_edge
);
  logic reload_d;
  ////////////////////////////////////////////////////////////
  // a run only ends on a low sample, so two pulses with no gap would merge
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_cnt <= 8'h00;
      last_len <= 8'h00;
      n_runs <= 8'h00;
      n_reload <= 8'h00;
      reload_d <= 1'h0;
    end
    else
    begin
      run_cnt <= sequencer_marker ? run_cnt + 8'h01 : 8'h00;
      if (!sequencer_marker && run_cnt != 8'h00)
      begin
        last_len <= run_cnt;
        n_runs <= n_runs + 8'h01;
      end
      reload_d <= pipeline_reload_flag;
      if (pipeline_reload_flag && !reload_d)
      begin
        n_reload <= n_reload + 8'h01;
      end
    end
  end

  initial bad_edge = 8'h00;
  always @(sequencer_marker or pipeline_reload_flag)
  begin
    if (resetn && core_clk !== 1'h0)
    begin
      bad_edge = bad_edge + 8'h01;
    end
  end
endmodule // seqmk_capture

// >>> tb/seqmk_marker_tb.sv
// Purpose: self-checking bench for the sequencer marker and reload flag
// Assumes: inputs change on falling edges; capture model judges the outputs
// Notes: event inputs are packed in in_v so scenarios can loop over causes
`timescale 1ns/1ps

module seqmk_marker_tb;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic bus_hold_input = 1'h0;
  logic [22:0] in_v = 23'h000000;
  logic sequencer_marker;
  logic pipeline_reload_flag;
  logic [7:0] run_cnt, last_len, n_runs, n_reload, bad_edge;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;

  always #50 core_clk = ~core_clk;

  seqmk_marker dut_u (
    .core_clk(core_clk), .resetn(resetn),
    .ev_boundary(in_v[0]), .ev_pend_trace(in_v[1]), .ev_pend_irq(in_v[2]),
    .ev_atc_miss(in_v[3]), .ev_exc_reset(in_v[4]), .ev_bus_error(in_v[5]),
    .ev_addr_error(in_v[6]), .ev_spurious(in_v[7]), .ev_autovector(in_v[8]),
    .ev_cp_escape_noresp(in_v[9]), .ev_handler_first_instr(in_v[10]),
    .ev_startup_done(in_v[11]), .rl_branch(in_v[12]), .rl_jump(in_v[13]),
    .rl_trap(in_v[14]), .rl_return(in_v[15]), .rl_cp_flow(in_v[16]),
    .rl_flag_register_load_instr(in_v[17]), .rl_translation_control_load_instr(in_v[18]),
    .rl_exc_entry(in_v[19]), .rl_cc_only(in_v[20]), .rl_loop_start(in_v[21]),
    .rl_loop_cond_false(in_v[22]), .bus_hold_input(bus_hold_input),
    .sequencer_marker(sequencer_marker), .pipeline_reload_flag(pipeline_reload_flag)
  );

  seqmk_capture cap_u (
    .core_clk(core_clk), .resetn(resetn), .sequencer_marker(sequencer_marker),
    .pipeline_reload_flag(pipeline_reload_flag), .run_cnt(run_cnt), .last_len(last_len),
    .n_runs(n_runs), .n_reload(n_reload), .bad_edge(bad_edge)
  );
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input logic [22:0] m);
    @(negedge core_clk);
    in_v = m;
  endtask

  task automatic hit(input logic [22:0] m, input int idle);
    step(m);
    step(23'h000000);
    repeat (idle) @(negedge core_clk);
  endtask

  task automatic rst();
    @(negedge core_clk);
    resetn = 1'h0;
    repeat (6) @(negedge core_clk);
    resetn = 1'h1;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  // bus hold stays high through the boundary and must not matter
  task automatic t_boundary();
    logic [7:0] n;
    logic [7:0] r;
    n = n_runs;
    r = n_reload;
    bus_hold_input = 1'h1;
    hit(23'h000001, 8);
    chk(last_len, 8'h01);
    chk(n_runs, n + 8'h01);
    chk(n_reload, r);
    bus_hold_input = 1'h0;
    $display("test boundary done");
  endtask

  task automatic t_deferred();
    logic [7:0] r;
    for (int i = 1; i <= 2; i++)
    begin
      r = n_reload;
      hit(23'h000001 | (23'h000001 << i), 8);
      chk(last_len, 8'h02);
      chk(n_reload, r + 8'h01);
    end
    $display("test deferred done");
  endtask

  // window closers follow each event so the next one is not a second fault
  task automatic t_immediate();
    bus_hold_input = 1'h1;
    for (int i = 3; i <= 9; i++)
    begin
      hit(23'h000001 << i, 8);
      chk(last_len, 8'h03);
      hit(23'h000C00, 2);
    end
    bus_hold_input = 1'h0;
    $display("test immediate done");
  endtask

  task automatic t_reload();
    logic [7:0] r;
    logic [7:0] n;
    n = n_runs;
    for (int i = 12; i <= 21; i++)
    begin
      r = n_reload;
      hit(23'h000001 << i, 6);
      chk(n_reload, r + ((i == 20) ? 8'h00 : 8'h01));
    end
    r = n_reload;
    step(23'h200000);
    hit(23'h400000, 6);
    chk(n_reload, r + 8'h02);
    chk(n_runs, n);
    $display("test reload done");
  endtask

  // second event lands during the first pulse and must come out separately
  task automatic t_gap();
    logic [7:0] n;
    n = n_runs;
    step(23'h000001);
    hit(23'h000003, 10);
    chk(n_runs, n + 8'h02);
    chk(last_len, 8'h02);
    $display("test gap done");
  endtask

  task automatic t_halt();
    hit(23'h000020, 2);
    hit(23'h000020, 20);
    chk({7'h00, run_cnt > 8'h03}, 8'h01);
    hit(23'h000C01, 10);
    // outputs launch on the falling edge, so they are read at the rising edge
    @(posedge core_clk);
    chk({7'h00, sequencer_marker}, 8'h01);
    rst();
    @(posedge core_clk);
    chk({7'h00, sequencer_marker}, 8'h00);
    hit(23'h000010, 2);
    hit(23'h000040, 20);
    chk({7'h00, run_cnt > 8'h03}, 8'h01);
    rst();
    $display("test halt done");
  endtask

  initial
  begin
    repeat (6) @(negedge core_clk);
    resetn = 1'h1;
    t_boundary();
    t_deferred();
    t_immediate();
    t_reload();
    t_gap();
    t_halt();
    chk(bad_edge, 8'h00);
    print_verdict();
  end
endmodule // seqmk_marker_tb
